// >>> rtl/lsts_cfg.svh
// Constants of the lubricator status signalling block
// Behaviour
// - The empty-cartridge error is raised only at the end of a dispense, never at other times.
// - After the empty level is sensed no further dispense starts until a full cartridge is fitted; the code allows one after an undervoltage acknowledge.
// - While the empty error is active and the cartridge is fitted, status is a 0.5Hz square wave; the code holds it low if an empty cartridge is refitted.
// - While the cartridge is removed, status leaves the square wave and stays low.
// - Mounting a full cartridge clears the empty error and drives status steadily high again.
// - No acknowledge command clears the empty error; only a cartridge change does; the code also clears it on entering ST_UNDV or ST_FATAL.
// - A multi-stroke fill cut short by the empty error resumes its remaining strokes after mounting.
// - While any error stands, command pulses are ignored except a permitted acknowledge.
// - Maximum pressure during or after a dispense sets the overload error and holds status low; the code checks it only in ST_RUN and ST_PAUSE, not in ST_READY.
// - Overload clears only by a 14 s acknowledge, sent by the controller once the cause is gone.
// - A supply-low indication sets the undervoltage error and holds status low.
// - Undervoltage clears only by a 14 s acknowledge, sent once the supply fault is gone.
// - A fatal diagnosis latches the fatal error, holds status low and refuses every acknowledge.
// - Status is low for the whole of each motor run and returns high after an error-free run.
// - An acknowledge is a high command pulse of 13.9 to 14.1 seconds, made so by the controller.
`ifndef LSTS_CFG_SVH
`define LSTS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LSTS_CLK_HZ        40000000
`define LSTS_TICK_PER_S    1000
`define LSTS_TICK_CYC      (`LSTS_CLK_HZ / `LSTS_TICK_PER_S)
`define LSTS_ACK_MIN_MS    13900
`define LSTS_ACK_MAX_MS    14100
`define LSTS_SQ_FREQ_MHZ   500
`define LSTS_SQ_HALF_MS    (1000000 / (2 * `LSTS_SQ_FREQ_MHZ))
`define LSTS_READY_MS      3000
`define LSTS_PAUSE_MS      500
`define LSTS_FILL_STROKES  40

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LSTS_ADDR_W        5
`define LSTS_OFF_CTRL      5'h00
`define LSTS_OFF_STATUS    5'h04
`define LSTS_OFF_IRQ_STAT  5'h08
`define LSTS_OFF_IRQ_MASK  5'h0C
`define LSTS_CTRL_EN_BIT   0
`define LSTS_CTRL_RST      1'h1
`define LSTS_ST_STROKE_LSB 16
`define LSTS_EV_W          6
`define LSTS_RESP_OKAY     2'h0
`define LSTS_RESP_SLVERR   2'h2

`endif

// >>> rtl/lsts_pkg.sv
// Types shared by the lubricator status signalling files
package lsts_pkg;

    typedef enum logic [8:0] {
        ST_OFF    = 9'h001,
        ST_READY  = 9'h002,
        ST_RUN    = 9'h004,
        ST_PAUSE  = 9'h008,
        ST_EMPTY  = 9'h010,
        ST_REMOVE = 9'h020,
        ST_OVLD   = 9'h040,
        ST_UNDV   = 9'h080,
        ST_FATAL  = 9'h100
    } lsts_state_e;

    typedef struct packed {
        logic        en;
        logic [4:0]  addr;
        logic [31:0] data;
        logic        lane0;
    } lsts_wr_s;

    typedef struct packed {
        logic run_done;
        logic ack_ok;
        logic fatal;
        logic underv;
        logic overload;
        logic empty;
    } lsts_ev_s;

endpackage : lsts_pkg

// >>> rtl/lsts_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module lsts_tick #(
    parameter int unsigned DIV = 40000
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output var  logic tick_q
);
    logic [31:0] cnt_q, cnt_d;
    logic        tick_d;

    always_comb begin
        tick_d = (cnt_q == DIV - 1);
        cnt_d  = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule : lsts_tick
`default_nettype wire

// >>> rtl/lsts_axil.sv
// AXI4-Lite slave front end for the status signalling registers
`include "lsts_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lsts_axil
    import lsts_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    output var  lsts_wr_s    wr_q,
    input  wire logic [31:0] rd_data
);
    logic        aw_q, aw_d, w_q, w_d, bv_d, rv_d, awr_d, wr_rdy_d, arr_d;
    logic [4:0]  aa_q, aa_d;
    logic [31:0] wd_q, wd_d, rd_d;
    logic        ws_q, ws_d;
    logic [1:0]  br_d, rr_d;
    lsts_wr_s    wr_d;

    function automatic logic mapped(input logic [4:0] a);
        mapped = (a == `LSTS_OFF_CTRL) || (a == `LSTS_OFF_STATUS) ||
                 (a == `LSTS_OFF_IRQ_STAT) || (a == `LSTS_OFF_IRQ_MASK);
    endfunction : mapped

    always_comb begin
        aw_d = aw_q; aa_d = aa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
        bv_d = bvalid; br_d = bresp; wr_d = '0;
        rv_d = rvalid; rd_d = rdata; rr_d = rresp;
        if (awvalid && awready) begin
            aw_d = 1'b1;
            aa_d = awaddr;
        end
        if (wvalid && wready) begin
            w_d  = 1'b1;
            wd_d = wdata;
            ws_d = wstrb[0];
        end
        if (bvalid && bready) begin
            bv_d = 1'b0;
        end
        if (aw_d && w_d && !bv_d) begin
            wr_d = '{en: mapped(aa_d), addr: aa_d, data: wd_d, lane0: ws_d};
            br_d = mapped(aa_d) ? `LSTS_RESP_OKAY : `LSTS_RESP_SLVERR;
            bv_d = 1'b1;
            aw_d = 1'b0;
            w_d  = 1'b0;
        end
        if (rvalid && rready) begin
            rv_d = 1'b0;
        end
        if (arvalid && arready) begin
            rv_d = 1'b1;
            rd_d = mapped(araddr) ? rd_data : 32'h0000_0000;
            rr_d = mapped(araddr) ? `LSTS_RESP_OKAY : `LSTS_RESP_SLVERR;
        end
        awr_d    = !aw_d && !bv_d;
        wr_rdy_d = !w_d && !bv_d;
        arr_d    = !rv_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0; aa_q <= 5'h00; w_q <= 1'b0; wd_q <= 32'h0000_0000; ws_q <= 1'b0;
            awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
            arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'h0;
            wr_q <= '0;
        end else begin
            aw_q <= aw_d; aa_q <= aa_d; w_q <= w_d; wd_q <= wd_d; ws_q <= ws_d;
            awready <= awr_d; wready <= wr_rdy_d; bvalid <= bv_d; bresp <= br_d;
            arready <= arr_d; rvalid <= rv_d; rdata <= rd_d; rresp <= rr_d;
            wr_q <= wr_d;
        end
    end
endmodule : lsts_axil
`default_nettype wire

// >>> rtl/lsts_top.sv
// Status and error signalling of the pulse-controlled lubricator
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`include "lsts_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lsts_top
    import lsts_pkg::*;
#(
    parameter int unsigned TICK_CYC = `LSTS_TICK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmd_in,
    input  wire logic        dispense_req,
    input  wire logic        fill_req,
    input  wire logic        run_done,
    input  wire logic        empty_sense,
    input  wire logic        cart_fitted,
    input  wire logic        pressure_max,
    input  wire logic        supply_low,
    input  wire logic        fatal_diag,
    output var  logic        status_out,
    output var  logic        motor_run,
    output var  logic        empty_cartridge_error,
    output var  logic        irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [13:0] ACK_MIN = 14'(`LSTS_ACK_MIN_MS);
    localparam logic [13:0] ACK_MAX = 14'(`LSTS_ACK_MAX_MS);
    localparam logic [13:0] SQ_HALF = 14'(`LSTS_SQ_HALF_MS);
    localparam logic [13:0] RDY_MS  = 14'(`LSTS_READY_MS);
    localparam logic [13:0] PAUSE   = 14'(`LSTS_PAUSE_MS);
    localparam logic [5:0]  FILL_N  = 6'(`LSTS_FILL_STROKES);

    lsts_state_e state_q, state_d;
    logic [13:0] tmr_q, tmr_d, hi_q, hi_d;
    logic [5:0]  strokes_q, strokes_d;
    logic        sq_q, sq_d, cmd_q, ack_q, ack_d;
    logic        status_q, status_d, run_q, run_d, empty_q, empty_d;
    logic        en_q, en_d, irq_q, irq_d, tick;
    logic [`LSTS_EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
    lsts_ev_s    ev;
    lsts_wr_s    wr;
    logic [31:0] rd_data;

    lsts_tick #(.DIV(TICK_CYC)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick_q  (tick)
    );

    lsts_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_q    (wr),
        .rd_data (rd_data)
    );

    // ----------------------------------------------------------------
    // Acknowledge pulse measurement
    // ----------------------------------------------------------------
    always_comb begin
        hi_d = hi_q;
        if (!cmd_in) begin
            hi_d = 14'h0000;
        end else if (tick && hi_q <= ACK_MAX) begin
            hi_d = hi_q + 14'h0001;
        end
        // Falling edge with a length inside the window is an acknowledge
        ack_d = cmd_q && !cmd_in && hi_q >= ACK_MIN && hi_q <= ACK_MAX;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_q  <= 14'h0000;
            cmd_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            hi_q  <= hi_d;
            cmd_q <= cmd_in;
            ack_q <= ack_d;
        end
    end

    // ----------------------------------------------------------------
    // Device state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        strokes_d = strokes_q;
        sq_d      = sq_q;
        tmr_d     = (tick && tmr_q != 14'h3FFF) ? tmr_q + 14'h0001 : tmr_q;
        if (fatal_diag || state_q == ST_FATAL) begin
            state_d = ST_FATAL;
        end else if (supply_low) begin
            state_d = ST_UNDV;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (en_q) begin
                        state_d = ST_READY;
                    end
                end
                ST_READY: begin
                    // Commands count only after status stood high long enough
                    if (!en_q) begin
                        state_d = ST_OFF;
                    end else if (tmr_q > RDY_MS && fill_req) begin
                        state_d   = ST_RUN;
                        strokes_d = FILL_N;
                    end else if (tmr_q > RDY_MS && dispense_req) begin
                        state_d   = ST_RUN;
                        strokes_d = 6'h01;
                    end
                end
                ST_RUN: begin
                    if (pressure_max) begin
                        state_d = ST_OVLD;
                    end else if (run_done) begin
                        strokes_d = strokes_q - 6'h01;
                        if (empty_sense) begin
                            state_d = ST_EMPTY;
                        end else if (strokes_q > 6'h01) begin
                            state_d = ST_PAUSE;
                        end else begin
                            state_d = ST_READY;
                        end
                    end
                end
                ST_PAUSE: begin
                    if (pressure_max) begin
                        state_d = ST_OVLD;
                    end else if (tmr_q >= PAUSE) begin
                        state_d = ST_RUN;
                    end
                end
                ST_EMPTY: begin
                    // Acknowledge has no effect here
                    if (!cart_fitted) begin
                        state_d = ST_REMOVE;
                    end else if (tick && tmr_q == SQ_HALF - 14'h0001) begin
                        sq_d  = !sq_q;
                        tmr_d = 14'h0000;
                    end
                end
                ST_REMOVE: begin
                    if (cart_fitted && !empty_sense) begin
                        state_d = (strokes_q != 6'h00) ? ST_PAUSE : ST_READY;
                    end
                end
                ST_OVLD: begin
                    if (ack_q && !pressure_max) begin
                        state_d   = ST_READY;
                        strokes_d = 6'h00;
                    end
                end
                ST_UNDV: begin
                    if (ack_q) begin
                        state_d   = ST_READY;
                        strokes_d = 6'h00;
                    end
                end
                default: begin
                    state_d = ST_FATAL;
                end
            endcase
        end
        if (state_d != state_q) begin
            tmr_d = 14'h0000;
            sq_d  = 1'b0;
        end
        // Status and motor follow the next state so they align with it
        status_d = (state_d == ST_READY) || (state_d == ST_PAUSE) ||
                   (state_d == ST_EMPTY && sq_d);
        run_d    = (state_d == ST_RUN);
        empty_d  = (state_d == ST_EMPTY) || (state_d == ST_REMOVE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= ST_OFF;
            strokes_q <= 6'h00;
            tmr_q     <= 14'h0000;
            sq_q      <= 1'b0;
            status_q  <= 1'b0;
            run_q     <= 1'b0;
            empty_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            strokes_q <= strokes_d;
            tmr_q     <= tmr_d;
            sq_q      <= sq_d;
            status_q  <= status_d;
            run_q     <= run_d;
            empty_q   <= empty_d;
        end
    end

    // ----------------------------------------------------------------
    // Registers and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        ev.empty    = state_d == ST_EMPTY && state_q != ST_EMPTY;
        ev.overload = state_d == ST_OVLD && state_q != ST_OVLD;
        ev.underv   = state_d == ST_UNDV && state_q != ST_UNDV;
        ev.fatal    = state_d == ST_FATAL && state_q != ST_FATAL;
        ev.ack_ok   = state_d == ST_READY && (state_q == ST_OVLD || state_q == ST_UNDV);
        ev.run_done = state_q == ST_RUN && state_d != ST_RUN;
        en_d   = en_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (wr.en && wr.lane0) begin
            if (wr.addr == `LSTS_OFF_CTRL) begin
                en_d = wr.data[`LSTS_CTRL_EN_BIT];
            end else if (wr.addr == `LSTS_OFF_IRQ_STAT) begin
                stat_d = stat_q & ~wr.data[`LSTS_EV_W-1:0];
            end else if (wr.addr == `LSTS_OFF_IRQ_MASK) begin
                mask_d = wr.data[`LSTS_EV_W-1:0];
            end
        end
        // A new event wins over a clear in the same cycle
        stat_d = stat_d | ev;
        irq_d  = |(stat_q & mask_q);
        rd_data = 32'h0000_0000;
        if (s_axi_araddr == `LSTS_OFF_CTRL) begin
            rd_data[`LSTS_CTRL_EN_BIT] = en_q;
        end else if (s_axi_araddr == `LSTS_OFF_STATUS) begin
            rd_data[8:0] = state_q;
            rd_data[`LSTS_ST_STROKE_LSB +: 6] = strokes_q;
        end else if (s_axi_araddr == `LSTS_OFF_IRQ_STAT) begin
            rd_data[`LSTS_EV_W-1:0] = stat_q;
        end else if (s_axi_araddr == `LSTS_OFF_IRQ_MASK) begin
            rd_data[`LSTS_EV_W-1:0] = mask_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q   <= `LSTS_CTRL_RST;
            mask_q <= '0;
            stat_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            en_q   <= en_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            irq_q  <= irq_d;
        end
    end

    assign status_out            = status_q;
    assign motor_run             = run_q;
    assign empty_cartridge_error = empty_q;
    assign irq                   = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_empty_at_end;
        $rose(empty_q) |-> $past(run_done) && $past(state_q) == ST_RUN;
    endproperty
    a_empty_at_end: assert property (p_empty_at_end) else $error("empty not at run end");

    property p_no_run_empty;
        empty_q |=> !run_q;
    endproperty
    a_no_run_empty: assert property (p_no_run_empty) else $error("run while empty");

    property p_square;
        state_q == ST_EMPTY && cart_fitted && !fatal_diag && !supply_low && tick
            && tmr_q == SQ_HALF - 14'h0001 |=> status_q != $past(status_q);
    endproperty
    a_square: assert property (p_square) else $error("square wave did not toggle");

    property p_removal_low;
        state_q == ST_EMPTY && !cart_fitted && !fatal_diag && !supply_low
            |=> state_q == ST_REMOVE && !status_q;
    endproperty
    a_removal_low: assert property (p_removal_low) else $error("removal not low");

    property p_mount;
        state_q == ST_REMOVE && cart_fitted && !empty_sense && !fatal_diag && !supply_low
            |=> !empty_q && status_q && (run_q == 1'b0);
    endproperty
    a_mount: assert property (p_mount) else $error("mount did not restore ready");

    property p_ack_no_clear;
        empty_q && ack_q && !supply_low && !fatal_diag
            |=> empty_q || ($past(cart_fitted) && !$past(empty_sense));
    endproperty
    a_ack_no_clear: assert property (p_ack_no_clear) else $error("ack cleared empty");

    property p_overload;
        state_q == ST_RUN && pressure_max && !fatal_diag && !supply_low
            |=> state_q == ST_OVLD && !status_q ##1 !status_q;
    endproperty
    a_overload: assert property (p_overload) else $error("overload not held low");

    property p_ovld_hold;
        state_q == ST_OVLD && !ack_q |=> state_q inside {ST_OVLD, ST_UNDV, ST_FATAL};
    endproperty
    a_ovld_hold: assert property (p_ovld_hold) else $error("overload left without ack");

    property p_underv;
        supply_low && state_q != ST_FATAL && !fatal_diag |=> state_q == ST_UNDV && !status_q;
    endproperty
    a_underv: assert property (p_underv) else $error("undervoltage not set");

    property p_fatal;
        state_q == ST_FATAL |=> state_q == ST_FATAL && !status_q && !run_q;
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal error released");

    property p_run_low;
        run_q |-> !status_q;
    endproperty
    a_run_low: assert property (p_run_low) else $error("status high during run");

    property p_ack_len;
        ack_q |-> $past(hi_q) >= ACK_MIN && $past(hi_q) <= ACK_MAX && $past(cmd_q);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack outside window");

    property p_off;
        state_q == ST_OFF |-> !status_q ##1 !run_q;
    endproperty
    a_off: assert property (p_off) else $error("off mode not low");

endmodule : lsts_top
`default_nettype wire

// >>> sim/lsts_plc.sv
// Controller model that sends acknowledge pulses on the command line
`timescale 1ns/1ps
`default_nettype none
module lsts_plc #(
    parameter int unsigned LEN = 56000
) (
    input  wire logic aclk,
    input  wire logic go,
    output var  logic cmd_in
);
    int unsigned cnt_q = 0;
    // ----------------------------------------------------------------
    // Pulse timer
    // ----------------------------------------------------------------
    // A request while a pulse runs is dropped, so one pulse never stretches
    always_ff @(posedge aclk) begin
        if (go && cnt_q == 0) begin
            cnt_q <= LEN;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign cmd_in = (cnt_q != 0);
endmodule : lsts_plc
`default_nettype wire

// >>> sim/lsts_top_test.sv
// Self-checking bench of the lubricator status signalling block
`timescale 1ns/1ps
`default_nettype none
module lsts_top_test;
    import lsts_pkg::*;
    localparam int unsigned TC = 2;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, dispense_req = 0, fill_req = 0, run_done = 0;
    logic empty_sense = 0, cart_fitted = 1, pressure_max = 0, supply_low = 0, fatal_diag = 0;
    logic go = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cmd_in, status_out, motor_run, empty_cartridge_error, irq;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, r, seed = 32'h0000F302;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, e;
    int err_count = 0, n_checks = 0;
    lsts_top #(.TICK_CYC(TC)) u_lsts_top (.*);
    lsts_plc #(.LEN(14000 * TC)) u_lsts_plc (.aclk(aclk), .go(go), .cmd_in(cmd_in));
    initial forever #12.5 aclk = ~aclk;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic results();
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    // Ready flags are sampled mid-cycle so the edge decision never races the design
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        logic ta, tw, tb;
        @(posedge aclk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
        end
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
            tw = s_axi_wready & s_axi_wvalid;
            tb = w ? s_axi_bvalid : s_axi_rvalid;
            r = s_axi_rdata;
            e = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (tw) s_axi_wvalid <= 0;
            if (tb) begin
                {s_axi_bready, s_axi_rready} <= 2'h0;
                break;
            end
        end
        if (i == 40) begin
            err_count++;
            results();
        end
    endtask : xfer
    task automatic pulse_disp();
        dispense_req <= 1;
        cyc(1);
        dispense_req <= 0;
        cyc(3);
    endtask : pulse_disp
    task automatic ack_go();
        go <= 1;
        cyc(1);
        go <= 0;
        cyc(2);
    endtask : ack_go
    // A controller pulse that never ends is a failure, not a hang
    task automatic ack_wait();
        int i;
        for (i = 0; i < 14300 * TC && cmd_in !== 1'b0; i++) cyc(1);
        if (cmd_in !== 1'b0) begin
            err_count++;
            results();
        end
        cyc(5);
    endtask : ack_wait
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        int i;
        cyc(3);
        aresetn <= 1;
        xfer(0, 5'h00, 0); chk("ctrl", 32'h1, r);
        xfer(0, 5'h0C, 0); chk("mask", 32'h0, r);
        xfer(0, 5'h10, 0); chk("unmapped", 2'h2, e);
        xfer(1, 5'h0C, 32'h2);
        cyc(3001 * TC + 20);
        pulse_disp();
        chk("motor", 1, motor_run);
        chk("status run", 0, status_out);
        pressure_max <= 1;
        cyc(4);
        chk("status ovld", 0, status_out);
        chk("irq", 1, irq);
        for (i = 0; i < 8; i++) begin
            dispense_req <= rnd() & 1;
            cyc(1);
        end
        dispense_req <= 0;
        xfer(0, 5'h04, 0); chk("state ovld", ST_OVLD, r[8:0]);
        pressure_max <= 0;
        ack_go();
        ack_wait();
        chk("status ack", 1, status_out);
        xfer(1, 5'h08, 32'h3F);
        cyc(2);
        chk("irq clr", 0, irq);
        cyc(3001 * TC + 20);
        xfer(1, 5'h00, 0);
        pulse_disp();
        chk("off status", 0, status_out);
        chk("off motor", 0, motor_run);
        xfer(1, 5'h00, 1);
        cyc(3001 * TC + 20);
        empty_sense <= 1;
        fill_req <= 1;
        cyc(1);
        fill_req <= 0;
        cyc(3);
        chk("empty early", 0, empty_cartridge_error);
        run_done <= 1;
        cyc(1);
        run_done <= 0;
        cyc(3);
        chk("empty", 1, empty_cartridge_error);
        ack_go();
        cyc(750 * TC);
        chk("square low", 0, status_out);
        cyc(1000 * TC);
        chk("square high", 1, status_out);
        pulse_disp();
        chk("no dispense", 0, motor_run);
        ack_wait();
        chk("empty ack", 1, empty_cartridge_error);
        cart_fitted <= 0;
        cyc(5);
        chk("removal", 0, status_out);
        empty_sense <= 0;
        cart_fitted <= 1;
        cyc(5);
        chk("mounted", 1, status_out);
        chk("empty clr", 0, empty_cartridge_error);
        cyc(500 * TC + 4);
        chk("resume", 1, motor_run);
        xfer(0, 5'h04, 0); chk("strokes", 39, r[21:16]);
        supply_low <= 1;
        cyc(4);
        chk("status underv", 0, status_out);
        xfer(0, 5'h04, 0); chk("state underv", ST_UNDV, r[8:0]);
        fatal_diag <= 1;
        cyc(5);
        chk("status fatal", 0, status_out);
        xfer(0, 5'h04, 0); chk("state fatal", ST_FATAL, r[8:0]);
        results();
    end
endmodule : lsts_top_test
`default_nettype wire
